// ### tsr_router.sv
// routes tdm and pcm slot words to converter paths and adc samples to slots
`timescale 1ns/1ns
`include "tsr_router_regs.svh"
module tsr_router import tsr_pkg::*; #(
    parameter int SW    = `TSR_SAMPLE_W,
    parameter int DEPTH = `TSR_FIFO_DEPTH
) (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic [1:0]          serial_format,
    input  wire logic                output_chain_enable,
    input  wire logic [2:0]          audio_dac_src_sel,
    input  wire logic [2:0]          low_latency_src_sel,
    input  wire logic [2:0]          tracking_dac_src_sel,
    input  wire logic                tracking_power_down,
    input  wire logic                rx_valid,
    output logic                     rx_ready,
    input  wire logic                rx_line,
    input  wire logic [3:0]          rx_slot,
    input  wire logic [31:0]         rx_data,
    input  wire logic [SW-1:0]       masked_track_sample,
    input  wire logic                sink_ready,
    output logic      [4*SW-1:0]     audio_dac_data,
    output logic                     audio_dac_valid,
    output logic      [4*SW-1:0]     low_latency_data,
    output logic                     low_latency_valid,
    output logic      [SW-1:0]       tracking_dac_data,
    output logic                     tracking_dac_valid,
    output logic                     tracking_dac_active,
    input  wire logic [4*SW-1:0]     delayed_audio,
    input  wire logic                delayed_valid,
    output logic      [4*SW-1:0]     mix_out,
    output logic                     mix_valid,
    input  wire logic [4*SW-1:0]     adc_samples,
    input  wire logic                adc_load,
    input  wire logic                tx_slot_valid,
    input  wire logic [3:0]          tx_slot,
    input  wire logic [31:0]         chain_in_word,
    output logic      [31:0]         serial_out_primary,
    output logic      [31:0]         serial_out_secondary,
    output logic                     tx_word_valid
);
    localparam int FW = 1 + `TSR_SLOT_IDX_W + `TSR_SLOT_W;
    localparam int PAD_W = `TSR_SLOT_W - SW;

    logic                 rx_ready_int;
    logic                 f_valid;
    logic                 f_ready;
    logic [FW-1:0]        f_data;
    logic                 w_line;
    logic [3:0]           w_slot;
    logic [31:0]          w_data;
    logic [SW-1:0]        w_sample;
    logic [1:0]           w_grp;
    logic [1:0]           w_ch;
    logic                 pop;
    logic                 is_tdm;
    tsr_fmt_t             fmt;
    tsr_trk_mode_t        trk_mode;

    logic [SW-1:0]        aud_q [`TSR_LANE_CNT];
    logic [SW-1:0]        ll_q  [`TSR_LANE_CNT];
    logic [SW-1:0]        trk_q;
    logic [SW-1:0]        adc_q [`TSR_LANE_CNT];
    logic [4*SW-1:0]      aud_out_q;
    logic [4*SW-1:0]      ll_out_q;
    logic [4*SW-1:0]      mix_q;
    logic [4*SW-1:0]      mix_sum;
    logic                 aud_vld_q;
    logic                 ll_vld_q;
    logic                 trk_vld_q;
    logic                 mix_vld_q;
    logic                 trk_act_q;
    logic [SW-1:0]        trk_out_q;
    logic [31:0]          pri_q;
    logic [31:0]          sec_q;
    logic                 tx_vld_q;

    logic                 aud_hit;
    logic [1:0]           aud_ch;
    logic                 aud_done;
    logic                 ll_hit;
    logic                 ll_done;
    logic                 trk_hit;
    logic                 trk_done;
    logic                 frame_end;
    logic                 rx_pcm_slot;
    logic                 tx_own_slot;
    logic                 tx_pcm_slot;
    logic [7:0]           w_trk_byte;
    logic [1:0]           trk_lane;

    // input slot words buffered ahead of the router
    tsr_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) i_tsr_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready_int),
        .in_data   ({rx_line, rx_slot, rx_data}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign rx_ready  = rx_ready_int;
    assign f_ready   = sink_ready;
    assign pop       = f_valid && sink_ready;
    assign w_line    = f_data[FW-1];
    assign w_slot    = f_data[FW-2 -: 4];
    assign w_data    = f_data[31:0];
    assign w_sample  = w_data[31 -: SW];
    assign w_grp     = w_slot[3:2];
    assign w_ch      = w_slot[1:0];
    assign fmt       = tsr_fmt_t'(serial_format);
    assign is_tdm    = (fmt == TSR_FMT_TDM);
    assign frame_end = (w_slot == `TSR_FRAME_LAST);
    assign rx_pcm_slot = (w_slot == `TSR_PCM_LEFT) || (w_slot == `TSR_PCM_RIGHT);
    assign tx_own_slot = (tx_slot <= `TSR_OWN_SLOT_MAX);
    assign tx_pcm_slot = (tx_slot == `TSR_PCM_LEFT) || (tx_slot == `TSR_PCM_RIGHT);
    assign w_trk_byte  = w_data[`TSR_TRK_BYTE_W-1:0];
    assign trk_lane    = `TSR_TRK_LAST_CH - w_ch;

    // tracking source decode
    always_comb begin
        if (tracking_dac_src_sel == `TSR_TRK_MASKED) begin
            trk_mode = TSR_TRK_MASK;
        end else if (tracking_dac_src_sel[2]) begin
            trk_mode = TSR_TRK_RSVD;
        end else begin
            trk_mode = TSR_TRK_SLOTS;
        end
    end

    // audio dac slot selection
    always_comb begin
        aud_hit  = 1'b0;
        aud_ch   = w_ch;
        aud_done = 1'b0;
        if (is_tdm) begin
            aud_hit  = (w_line == audio_dac_src_sel[2])
                       && (w_grp == audio_dac_src_sel[1:0]);
            aud_done = aud_hit && (w_ch == `TSR_GRP_LAST_CH);
        end else begin
            aud_hit  = rx_pcm_slot;
            aud_ch   = {w_line, w_slot[0]};
            aud_done = aud_hit && w_line && (w_slot == `TSR_PCM_RIGHT);
        end
    end

    // low-latency and tracking slot selection
    always_comb begin
        ll_hit   = is_tdm && (w_line == low_latency_src_sel[2])
                   && (w_grp == low_latency_src_sel[1:0]);
        ll_done  = ll_hit && (w_ch == `TSR_GRP_LAST_CH);
        trk_hit  = is_tdm && (trk_mode == TSR_TRK_SLOTS) && !w_line
                   && (w_grp == tracking_dac_src_sel[1:0]) && (w_ch != `TSR_GRP_LAST_CH);
        trk_done = trk_hit && (w_ch == `TSR_TRK_LAST_CH);
    end

    // audio dac sample capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < `TSR_LANE_CNT; i++) begin
                aud_q[i] <= '0;
            end
        end else if (pop && aud_hit) begin
            aud_q[aud_ch] <= w_sample;
        end
    end

    // low-latency sample capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < `TSR_LANE_CNT; i++) begin
                ll_q[i] <= '0;
            end
        end else if (!is_tdm) begin
            for (int i = 0; i < `TSR_LANE_CNT; i++) begin
                ll_q[i] <= '0;
            end
        end else if (pop && ll_hit) begin
            ll_q[w_ch] <= w_sample;
        end
    end

    // tracking sample assembly
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trk_q <= '0;
        end else if (pop && trk_hit) begin
            trk_q[trk_lane * `TSR_TRK_BYTE_W +: `TSR_TRK_BYTE_W] <= w_trk_byte;
        end
    end

    // audio dac output words
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aud_out_q <= '0;
            aud_vld_q <= 1'b0;
        end else begin
            aud_vld_q <= pop && aud_done;
            if (pop && aud_done) begin
                aud_out_q <= {w_sample, aud_q[2], aud_q[1], aud_q[0]};
            end
        end
    end

    // low-latency output words
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ll_out_q <= '0;
            ll_vld_q <= 1'b0;
        end else begin
            ll_vld_q <= pop && ll_done;
            if (!is_tdm) begin
                ll_out_q <= '0;
            end else if (pop && ll_done) begin
                ll_out_q <= {w_sample, ll_q[2], ll_q[1], ll_q[0]};
            end
        end
    end

    // tracking output word
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trk_out_q <= '0;
            trk_vld_q <= 1'b0;
        end else begin
            trk_vld_q <= 1'b0;
            if (pop && is_tdm) begin
                if (trk_done) begin
                    trk_out_q <= {trk_q[SW-1:`TSR_TRK_BYTE_W], w_trk_byte};
                    trk_vld_q <= 1'b1;
                end else if (frame_end && trk_mode == TSR_TRK_MASK) begin
                    trk_out_q <= masked_track_sample;
                    trk_vld_q <= 1'b1;
                end else if (frame_end && trk_mode == TSR_TRK_RSVD) begin
                    trk_out_q <= '0;
                    trk_vld_q <= 1'b1;
                end
            end
        end
    end

    // tracking dac activity
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trk_act_q <= 1'b0;
        end else begin
            trk_act_q <= !tracking_power_down;
        end
    end

    // low-latency mix lanes
    // post-delay mix lanes
    for (genvar g = 0; g < `TSR_LANE_CNT; g++) begin : g_mix
        tsr_sat_add #(
            .W (SW)
        ) i_tsr_sat_add (
            .a   (delayed_audio[g*SW +: SW]),
            .b   (ll_out_q[g*SW +: SW]),
            .sum (mix_sum[g*SW +: SW])
        );
    end

    // mix register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mix_q     <= '0;
            mix_vld_q <= 1'b0;
        end else begin
            mix_vld_q <= delayed_valid;
            if (delayed_valid) begin
                mix_q <= mix_sum;
            end
        end
    end

    // adc sample latch
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < `TSR_LANE_CNT; i++) begin
                adc_q[i] <= '0;
            end
        end else if (adc_load) begin
            for (int i = 0; i < `TSR_LANE_CNT; i++) begin
                adc_q[i] <= adc_samples[i*SW +: SW];
            end
        end
    end

    // outgoing slot words
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pri_q    <= '0;
            sec_q    <= '0;
            tx_vld_q <= 1'b0;
        end else begin
            tx_vld_q <= tx_slot_valid;
            if (tx_slot_valid) begin
                pri_q <= '0;
                sec_q <= '0;
                if (is_tdm) begin
                    if (tx_own_slot) begin
                        pri_q <= {adc_q[tx_slot[1:0]], {PAD_W{1'b0}}};
                    end else if (output_chain_enable) begin
                        pri_q <= chain_in_word;
                    end
                end else if (tx_pcm_slot) begin
                    pri_q <= {adc_q[tx_slot[0]], {PAD_W{1'b0}}};
                    sec_q <= {adc_q[{1'b1, tx_slot[0]}], {PAD_W{1'b0}}};
                end
            end
        end
    end

    assign audio_dac_data      = aud_out_q;
    assign audio_dac_valid     = aud_vld_q;
    assign low_latency_data    = ll_out_q;
    assign low_latency_valid   = ll_vld_q;
    assign tracking_dac_data   = trk_out_q;
    assign tracking_dac_valid  = trk_vld_q;
    assign tracking_dac_active = trk_act_q;
    assign mix_out             = mix_q;
    assign mix_valid           = mix_vld_q;
    assign serial_out_primary  = pri_q;
    assign serial_out_secondary = sec_q;
    assign tx_word_valid       = tx_vld_q;
endmodule

// ### tsr_router_regs.svh
// constants for the tdm slot path router
`ifndef TSR_ROUTER_REGS_SVH
`define TSR_ROUTER_REGS_SVH
`define TSR_SLOT_W        32
`define TSR_SAMPLE_W      24
`define TSR_SLOT_IDX_W    4
`define TSR_LANE_CNT      4
`define TSR_FIFO_DEPTH    8
`define TSR_SAMPLE_LSB    8
`define TSR_TRK_BYTE_W    8
`define TSR_GRP_LAST_CH   2'h3
`define TSR_TRK_LAST_CH   2'h2
`define TSR_FRAME_LAST    4'hf
`define TSR_TRK_MASKED    3'h4
`define TSR_OWN_SLOT_MAX  4'h3
`define TSR_CHAIN_SLOT_MAX 4'hf
`define TSR_PCM_LEFT      4'h0
`define TSR_PCM_RIGHT     4'h1
`endif

// ### tsr_pkg.sv
// types shared by the tdm slot path router
package tsr_pkg;
    typedef enum logic [1:0] {
        TSR_FMT_LJ,
        TSR_FMT_I2S,
        TSR_FMT_TDM
    } tsr_fmt_t;
    typedef logic signed [23:0] tsr_sample_t;
    typedef enum logic [1:0] {
        TSR_TRK_SLOTS,
        TSR_TRK_MASK,
        TSR_TRK_RSVD
    } tsr_trk_mode_t;
endpackage

// ### tsr_fifo.sv
// slot word fifo with valid and ready on both sides
`timescale 1ns/1ns
module tsr_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             rdy_q;
    logic             push;
    logic             pop;

    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next fill count
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

// ### tsr_sat_add.sv
// saturating signed adder for one mix lane
`timescale 1ns/1ns
module tsr_sat_add #(
    parameter int W = 24
) (
    input  wire logic signed [W-1:0] a,
    input  wire logic signed [W-1:0] b,
    output logic signed      [W-1:0] sum
);
    logic signed [W:0] wide;
    assign wide = {a[W-1], a} + {b[W-1], b};
    always_comb begin
        if (wide[W] != wide[W-1]) begin
            sum = wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            sum = wide[W-1:0];
        end
    end
endmodule

// ### tsr_router_props.sv
// concurrent checks on the router top ports
`timescale 1ns/1ns
module tsr_router_props #(
    parameter int SW    = 24,
    parameter int DEPTH = 8
) (
    input wire logic          ref_clk,
    input wire logic          srst,
    input wire logic [1:0]    serial_format,
    input wire logic          output_chain_enable,
    input wire logic [2:0]    tracking_dac_src_sel,
    input wire logic          tracking_power_down,
    input wire logic [SW-1:0] masked_track_sample,
    input wire logic [SW-1:0] tracking_dac_data,
    input wire logic          tracking_dac_valid,
    input wire logic          tracking_dac_active,
    input wire logic          low_latency_valid,
    input wire logic          delayed_valid,
    input wire logic          mix_valid,
    input wire logic          tx_slot_valid,
    input wire logic [3:0]    tx_slot,
    input wire logic [31:0]   chain_in_word,
    input wire logic [31:0]   serial_out_primary,
    input wire logic [31:0]   serial_out_secondary,
    input wire logic          tx_word_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic tdm;
    assign tdm = (serial_format == 2'h2);
    a_tx_answer: assert property (tx_slot_valid |=> tx_word_valid)
        else $error("slot request got no answer");
    a_tx_no_extra: assert property (tx_word_valid |-> $past(tx_slot_valid))
        else $error("slot answer without request");
    a_adc_slot_low: assert property (tdm && tx_slot_valid && tx_slot <= 4'h3
        |=> serial_out_primary[7:0] == 8'h00 && serial_out_secondary == 32'h0000_0000)
        else $error("adc slot word malformed");
    a_chain_word: assert property (tdm && tx_slot_valid && tx_slot > 4'h3
        && output_chain_enable |=> serial_out_primary == $past(chain_in_word))
        else $error("chained word not forwarded");
    a_chain_off: assert property (tdm && tx_slot_valid && tx_slot > 4'h3
        && !output_chain_enable |=> serial_out_primary == 32'h0000_0000)
        else $error("chain slot not zero with chain off");
    a_pcm_quiet: assert property (!tdm && tx_slot_valid && tx_slot > 4'h1
        |=> serial_out_primary == 32'h0000_0000 && serial_out_secondary == 32'h0000_0000)
        else $error("pcm spare slot not zero");
    a_mix_answer: assert property (delayed_valid |=> mix_valid)
        else $error("mix result missing");
    a_track_active: assert property (!$past(srst)
        |-> tracking_dac_active == !$past(tracking_power_down))
        else $error("tracking active does not follow power down");
    a_masked_src: assert property (tracking_dac_valid && tracking_dac_src_sel == 3'h4
        |-> tracking_dac_data == masked_track_sample)
        else $error("masked tracking source not used");
    a_rsvd_zero: assert property (tracking_dac_valid && tracking_dac_src_sel > 3'h4
        |-> tracking_dac_data == '0)
        else $error("reserved tracking code gave data");
    a_pcm_no_ll: assert property (!tdm && $past(serial_format, 3) != 2'h2
        |-> !low_latency_valid && !tracking_dac_valid)
        else $error("pcm mode updated tdm only path");
endmodule
bind tsr_router tsr_router_props #(.SW(SW), .DEPTH(DEPTH)) i_tsr_router_props (
    .ref_clk, .srst, .serial_format, .output_chain_enable, .tracking_dac_src_sel,
    .tracking_power_down, .masked_track_sample, .tracking_dac_data, .tracking_dac_valid,
    .tracking_dac_active, .low_latency_valid, .delayed_valid, .mix_valid, .tx_slot_valid,
    .tx_slot, .chain_in_word, .serial_out_primary, .serial_out_secondary, .tx_word_valid
);

// ### tsr_dsp_model.sv
// controller model: sends both input lines of one tdm frame as slot words
`timescale 1ns/1ns
module tsr_dsp_model (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [31:0] base,
    input  wire logic        rx_ready,
    output logic             rx_valid,
    output logic             rx_line,
    output logic [3:0]       rx_slot,
    output logic [31:0]      rx_data
);
    logic [4:0] n;
    assign {rx_line, rx_slot} = n;
    initial begin
        rx_valid = 1'b0;
        n = 5'h00;
        rx_data = 32'h0000_0000;
    end
    // each slot word sent once, line 0 then line 1
    always @(posedge ref_clk) begin
        if (go && !rx_valid) begin
            rx_valid <= 1'b1;
            n <= 5'h00;
            rx_data <= base;
        end else if (rx_valid && rx_ready && n == 5'h1f) begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
        end else if (rx_valid && rx_ready) begin
            n <= n + 5'h01;
            rx_data <= base ^ {4{n + 5'h01, 3'h0}};
        end
    end
endmodule

// ### tb_tsr_router.sv
// self-checking bench for the tdm slot path router
`timescale 1ns/1ns
module tb_tsr_router import tsr_pkg::*; ;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  serial_format = 2'h0;
    logic        output_chain_enable = 1'b0;
    logic [2:0]  audio_dac_src_sel = 3'h0;
    logic [2:0]  low_latency_src_sel = 3'h0;
    logic [2:0]  tracking_dac_src_sel = 3'h0;
    logic        tracking_power_down = 1'b1;
    logic        sink_ready = 1'b1;
    logic        delayed_valid = 1'b0;
    logic        adc_load = 1'b0;
    logic        tx_slot_valid = 1'b0;
    logic        go = 1'b0;
    logic        stall = 1'b0;
    logic        flush = 1'b0;
    logic [3:0]  tx_slot = 4'h0;
    logic [23:0] masked_track_sample = 24'h00_0000;
    logic [31:0] base = 32'h0000_0000;
    logic [31:0] chain_in_word = 32'h0000_0000;
    logic [95:0] delayed_audio = 96'h0;
    logic [95:0] adc_samples = 96'h0;
    logic [95:0] ll_cur = 96'h0;
    logic        rx_valid, rx_ready, rx_line, audio_dac_valid, low_latency_valid;
    logic        tracking_dac_valid, tracking_dac_active, mix_valid, tx_word_valid;
    logic [3:0]  rx_slot;
    logic [31:0] rx_data, serial_out_primary, serial_out_secondary;
    logic [23:0] tracking_dac_data;
    logic [95:0] audio_dac_data, low_latency_data, mix_out;
    logic [95:0] q_aud[$], q_ll[$], q_trk[$], q_mix[$], q_tx[$];
    integer      seed = 77688;
    int          err_total = 0;
    int          check_count = 0;
    tsr_router i_tsr_router (
        .ref_clk, .srst, .serial_format, .output_chain_enable, .audio_dac_src_sel,
        .low_latency_src_sel, .tracking_dac_src_sel, .tracking_power_down, .rx_valid,
        .rx_ready, .rx_line, .rx_slot, .rx_data, .masked_track_sample, .sink_ready,
        .audio_dac_data, .audio_dac_valid, .low_latency_data, .low_latency_valid,
        .tracking_dac_data, .tracking_dac_valid, .tracking_dac_active, .delayed_audio,
        .delayed_valid, .mix_out, .mix_valid, .adc_samples, .adc_load, .tx_slot_valid,
        .tx_slot, .chain_in_word, .serial_out_primary, .serial_out_secondary, .tx_word_valid
    );
    tsr_dsp_model i_tsr_dsp_model (
        .ref_clk, .go, .base, .rx_ready, .rx_valid, .rx_line, .rx_slot, .rx_data
    );
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) sink_ready <= stall ? 1'b0 : (flush || 1'($random(seed)));
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [95:0] pop(ref logic [95:0] q[$]);
        return q.size() > 0 ? q.pop_front() : 96'hx;
    endfunction
    function automatic logic [31:0] word(input logic [4:0] n);
        return base ^ {4{n, 3'h0}};
    endfunction
    function automatic logic [95:0] lanes(input logic [19:0] ns);
        logic [95:0] r;
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            w = word(ns[5*i +: 5]);
            r[24*i +: 24] = w[31:8];
        end
        return r;
    endfunction
    function automatic logic [23:0] sat(input logic [23:0] a, input logic [23:0] b);
        logic [24:0] s;
        s = {a[23], a} + {b[23], b};
        return (s[24] != s[23]) ? {s[24], {23{~s[24]}}} : s[23:0];
    endfunction
    always @(posedge ref_clk) begin
        if (audio_dac_valid === 1'b1) check(audio_dac_data, pop(q_aud));
        if (low_latency_valid === 1'b1) check(low_latency_data, pop(q_ll));
        if (tracking_dac_valid === 1'b1) check(96'(tracking_dac_data), pop(q_trk));
        if (mix_valid === 1'b1) check(mix_out, pop(q_mix));
        if (tx_word_valid === 1'b1)
            check(96'({serial_out_primary, serial_out_secondary}), pop(q_tx));
    end
    task automatic frame(input logic [2:0] c);
        logic [2:0]  t;
        logic [31:0] w0, w1, w2;
        t = c ^ 3'h1;
        base <= $random(seed);
        audio_dac_src_sel <= c;
        low_latency_src_sel <= c ^ 3'h4;
        tracking_dac_src_sel <= t;
        stall <= (c == 3'h3);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        w0 = word({t[1:0], 2'h0});
        w1 = word({t[1:0], 2'h1});
        w2 = word({t[1:0], 2'h2});
        // pcm lines feed lanes in pairs
        if (serial_format != TSR_FMT_TDM) q_aud.push_back(lanes({5'h11, 5'h10, 5'h01, 5'h00}));
        else begin
            q_aud.push_back(lanes({c, 2'h3, c, 2'h2, c, 2'h1, c, 2'h0}));
            ll_cur = lanes({~c[2], c[1:0], 2'h3, ~c[2], c[1:0], 2'h2,
                            ~c[2], c[1:0], 2'h1, ~c[2], c[1:0], 2'h0});
            q_ll.push_back(ll_cur);
            // masked and reserved codes answer twice a frame
            if (t < 3'h4) q_trk.push_back(96'({w0[7:0], w1[7:0], w2[7:0]}));
            else repeat (2) q_trk.push_back(t == 3'h4 ? 96'(masked_track_sample) : 96'h0);
        end
        if (c == 3'h3) begin
            repeat (24) @(posedge ref_clk);
            @(negedge ref_clk);
            check(96'(rx_ready), 96'h0);
            @(posedge ref_clk);
            stall <= 1'b0;
        end
        for (int k = 0; k < 400 && (rx_valid || q_aud.size() + q_ll.size() + q_trk.size() > 0);
             k++) @(posedge ref_clk);
        // empty the fifo tail before the next frame changes the source codes
        flush <= 1'b1;
        repeat (10) @(posedge ref_clk);
        flush <= 1'b0;
    endtask
    task automatic mix_run(input logic [95:0] d);
        logic [95:0] e;
        for (int i = 0; i < 4; i++) e[24*i +: 24] = sat(d[24*i +: 24], ll_cur[24*i +: 24]);
        delayed_audio <= d;
        delayed_valid <= 1'b1;
        q_mix.push_back(e);
        @(posedge ref_clk);
        delayed_valid <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic tx_run();
        logic [31:0] p, s, r;
        adc_samples <= {$random(seed), $random(seed), $random(seed)};
        adc_load <= 1'b1;
        @(posedge ref_clk);
        adc_load <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            p = 32'h0000_0000;
            s = 32'h0000_0000;
            // chain slots carry the chained word only when enabled
            if (serial_format == TSR_FMT_TDM && i > 3) p = output_chain_enable ? r : 32'h0;
            else if (serial_format == TSR_FMT_TDM || i < 2) p = {adc_samples[24*i +: 24], 8'h00};
            // pcm inputs three and four on the secondary line
            if (serial_format != TSR_FMT_TDM && i < 2) s = {adc_samples[24*i+48 +: 24], 8'h00};
            chain_in_word <= r;
            tx_slot <= 4'(i);
            tx_slot_valid <= 1'b1;
            q_tx.push_back(96'({p, s}));
            @(posedge ref_clk);
        end
        tx_slot_valid <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        masked_track_sample <= 24'($random(seed));
        serial_format <= TSR_FMT_TDM;
        tracking_power_down <= 1'b0;
        @(posedge ref_clk);
        for (int c = 0; c < 8; c++) frame(3'(c));
        mix_run({$random(seed), $random(seed), $random(seed)});
        mix_run({4{24'h7f_ffff}});
        tx_run();
        // chain bit set before chained slots are used
        output_chain_enable <= 1'b1;
        tx_run();
        for (int f = 0; f < 2; f++) begin
            serial_format <= f ? TSR_FMT_I2S : TSR_FMT_LJ;
            @(posedge ref_clk);
            frame(3'h0);
            tx_run();
        end
        repeat (2) @(posedge ref_clk);
        check(96'(q_aud.size() + q_ll.size() + q_trk.size()), 96'h0);
        check(96'(q_tx.size() + q_mix.size()), 96'h0);
        // controller powers the tracking dac down in pcm
        tracking_power_down <= 1'b1;
        @(negedge ref_clk);
        check(96'(tracking_dac_active), 96'h1);
        @(negedge ref_clk);
        check(96'(tracking_dac_active), 96'h0);
        summarize();
    end
endmodule
